// ==== mmd_pkg.sv ====
// Purpose: shared constants for the magnetometer min/max and degauss control
// Assumes: 8-bit register space, 16-bit signed magnetic samples
// Notes: register offsets are byte addresses on the register port
package mmd_pkg;
  localparam int SAMPLE_W = 16;
  localparam logic [7:0] ADDR_OUT_Z_MSB = 8'h05;
  localparam logic [7:0] ADDR_OUT_Z_LSB = 8'h06;
  localparam logic [7:0] ADDR_MAG_OUT_X_MSB = 8'h33;
  localparam logic [7:0] ADDR_MAG_CONTROL_ONE = 8'h5b;
  localparam logic [7:0] ADDR_MAG_CONTROL_TWO = 8'h5c;
  localparam logic [7:0] MAG_CONTROL_ONE_RESET = 8'h00;
  localparam logic [7:0] MAG_CONTROL_TWO_RESET = 8'h00;
  // mag_control_one fields
  localparam int C1_ACAL_BIT = 7;
  localparam int C1_ONESHOT_RST_BIT = 6;
  localparam int C1_HMS_LSB = 0;
  localparam logic [1:0] HMS_HYBRID = 2'h3;
  // mag_control_two fields
  localparam logic [7:0] C2_WRITE_MASK = 8'h3f;
  localparam int C2_HYB_AUTOINC_BIT = 5;
  localparam int C2_MAXMIN_DIS_BIT = 4;
  localparam int C2_MAXMIN_DIS_THS_BIT = 3;
  localparam int C2_MAXMIN_RST_BIT = 2;
  localparam int C2_RST_CNT_LSB = 0;
  // extreme register reset values
  localparam logic [15:0] MIN_RESET = 16'h7fff;
  localparam logic [15:0] MAX_RESET = 16'h8000;
  // degauss frequency codes and periods in output-data-rate cycles
  localparam logic [1:0] RST_CNT_EVERY = 2'h0;
  localparam logic [1:0] RST_CNT_16 = 2'h1;
  localparam logic [1:0] RST_CNT_512 = 2'h2;
  localparam logic [1:0] RST_CNT_OFF = 2'h3;
  localparam logic [8:0] PERIOD_16_LAST = 9'h00f;
  localparam logic [8:0] PERIOD_512_LAST = 9'h1ff;
  // degauss pulse length
  localparam int CLOCK_MHZ = 200;
  localparam int DEGAUSS_PULSE_NS = 100;
  localparam int DEGAUSS_PULSE_CYC = (DEGAUSS_PULSE_NS * CLOCK_MHZ + 999) / 1000;
  typedef enum logic [1:0] {
    MMD_DG_IDLE = 2'b01,
    MMD_DG_PULSE = 2'b10
  } mmd_dg_state_t;
endpackage : mmd_pkg

// ==== mmd_track_if.sv ====
// Purpose: carrier between the control top and the min/max tracker
// Assumes: all signals on the one system clock
// Notes: axes packed x in low bits, then y, then z
interface mmd_track_if;
  logic track_en;
  logic clear;
  logic sample_valid;
  logic [3*mmd_pkg::SAMPLE_W-1:0] sample;
  logic [3*mmd_pkg::SAMPLE_W-1:0] max_val;
  logic [3*mmd_pkg::SAMPLE_W-1:0] min_val;
  logic clear_done;
  modport ctrl (output track_en, output clear, output sample_valid, output sample,
    input max_val, input min_val, input clear_done);
  modport trk (input track_en, input clear, input sample_valid, input sample,
    output max_val, output min_val, output clear_done);
endinterface : mmd_track_if

// ==== mmd_minmax.sv ====
// Purpose: per-axis signed minimum and maximum tracking
// Assumes: samples arrive as one-cycle valid strobes
// Notes: clear loads full-scale opposites so the first sample wins
module mmd_minmax (
  input wire logic clock,
  input wire logic rst_n,
  mmd_track_if.trk t
);
  localparam int W = mmd_pkg::SAMPLE_W;
  logic [3*W-1:0] max_ff, min_ff, nxt_max, nxt_min;
  logic done_ff, nxt_done;

  // next extremes for each axis
  always_comb begin
    nxt_max = max_ff;
    nxt_min = min_ff;
    nxt_done = t.clear;
    for (int a = 0; a < 3; a++) begin
      if (t.clear) begin
        nxt_max[a*W +: W] = mmd_pkg::MAX_RESET;
        nxt_min[a*W +: W] = mmd_pkg::MIN_RESET;
      end else if (t.track_en && t.sample_valid) begin
        if ($signed(t.sample[a*W +: W]) > $signed(max_ff[a*W +: W])) begin
          nxt_max[a*W +: W] = t.sample[a*W +: W];
        end
        if ($signed(t.sample[a*W +: W]) < $signed(min_ff[a*W +: W])) begin
          nxt_min[a*W +: W] = t.sample[a*W +: W];
        end
      end
    end
  end

  // register extremes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      max_ff <= {3{mmd_pkg::MAX_RESET}};
      min_ff <= {3{mmd_pkg::MIN_RESET}};
      done_ff <= 1'b0;
    end else begin
      max_ff <= nxt_max;
      min_ff <= nxt_min;
      done_ff <= nxt_done;
    end
  end

  assign t.max_val = max_ff;
  assign t.min_val = min_ff;
  assign t.clear_done = done_ff;
endmodule : mmd_minmax

// ==== mmd_degauss.sv ====
// Purpose: schedules the magnetic sensor reset pulse
// Assumes: odr_start is a one-cycle strobe at the start of each data-rate cycle
// Notes: requests during a running pulse are merged into it
module mmd_degauss (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [1:0] rst_cnt,
  input wire logic odr_start,
  input wire logic wake,
  input wire logic oneshot_req,
  output logic pulse,
  output logic oneshot_done
);
  mmd_pkg::mmd_dg_state_t st_ff, nxt_st;
  logic [8:0] odr_cnt_ff, nxt_odr_cnt;
  logic [7:0] len_ff, nxt_len;
  logic done_ff, nxt_done;
  logic periodic;

  // period counter and pulse sequencer
  always_comb begin
    periodic = 1'b0;
    nxt_odr_cnt = odr_cnt_ff;
    if (odr_start) begin
      case (rst_cnt)
        mmd_pkg::RST_CNT_EVERY: periodic = 1'b1;
        mmd_pkg::RST_CNT_16: periodic = (odr_cnt_ff[3:0] == mmd_pkg::PERIOD_16_LAST[3:0]);
        mmd_pkg::RST_CNT_512: periodic = (odr_cnt_ff == mmd_pkg::PERIOD_512_LAST);
        default: periodic = 1'b0;
      endcase
      nxt_odr_cnt = odr_cnt_ff + 9'h001;
    end
    nxt_st = st_ff;
    nxt_len = len_ff;
    nxt_done = 1'b0;
    case (st_ff)
      mmd_pkg::MMD_DG_IDLE: begin
        // one-shot bit is still set in the done cycle; done blocks a second pulse
        if (periodic || wake || (oneshot_req && !done_ff)) begin
          nxt_st = mmd_pkg::MMD_DG_PULSE;
          nxt_len = 8'(mmd_pkg::DEGAUSS_PULSE_CYC - 1);
        end
      end
      mmd_pkg::MMD_DG_PULSE: begin
        if (len_ff == 8'h00) begin
          nxt_st = mmd_pkg::MMD_DG_IDLE;
          nxt_done = oneshot_req;
        end else begin
          nxt_len = len_ff - 8'h01;
        end
      end
      default: nxt_st = mmd_pkg::MMD_DG_IDLE;
    endcase
  end

  // register sequencer state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= mmd_pkg::MMD_DG_IDLE;
      odr_cnt_ff <= 9'h000;
      len_ff <= 8'h00;
      done_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      odr_cnt_ff <= nxt_odr_cnt;
      len_ff <= nxt_len;
      done_ff <= nxt_done;
    end
  end

  assign pulse = (st_ff == mmd_pkg::MMD_DG_PULSE);
  assign oneshot_done = done_ff;
endmodule : mmd_degauss

// ==== mmd_ctrl.sv ====
// Purpose: magnetometer burst pointer, min/max tracking and degauss control
// Assumes: register port, samples and strobes come from logic on the same clock
// Notes: fast_read and active_mode come from the system control register outside
// Function
// - hybrid autoinc, normal read: 0x06 jumps 0x33
// - hybrid autoinc, fast read: 0x05 jumps 0x33
// - disable bit 0 tracks, 1 stops
// - track axis extremes each data-rate cycle
// - threshold event stops tracking when enabled
// - reset loads min 0x7FFF, max 0x8000
// - reset bit self-clears when done
// - code 00: degauss every cycle
// - code 01: degauss every 16 cycles
// - code 10: degauss every 512 cycles
// - code 11: no periodic degauss
// - standby to active always degausses once
// - host one-shot bit requests degauss
// - extremes feed the auto-calibration
// - one-shot bit clears after degauss
// - auto-cal loads offset with average
// - sensor select 0b11 means hybrid
module mmd_ctrl (
  input wire logic clock,
  input wire logic resetn,
  input wire logic reg_start,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic fast_read,
  input wire logic active_mode,
  input wire logic odr_start,
  input wire logic odr_end,
  input wire logic sample_valid,
  input wire logic [3*mmd_pkg::SAMPLE_W-1:0] mag_sample,
  input wire logic ths_event,
  output logic [7:0] reg_rdata,
  output logic [7:0] addr_ptr,
  output logic hybrid_mode,
  output logic degauss_pulse,
  output logic [3*mmd_pkg::SAMPLE_W-1:0] max_out,
  output logic [3*mmd_pkg::SAMPLE_W-1:0] min_out,
  output logic [3*mmd_pkg::SAMPLE_W-1:0] offset_out
);
  localparam int W = mmd_pkg::SAMPLE_W;

  // half of the sum of two signed values, widened to avoid overflow
  function automatic logic [W-1:0] avg2(input logic [W-1:0] a, input logic [W-1:0] b);
    logic signed [W:0] s;
    s = $signed({a[W-1], a}) + $signed({b[W-1], b});
    return s[W:1];
  endfunction : avg2

  // reset release through two flops
  logic rst_s1_ff, rst_n_ff;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff <= rst_s1_ff;
    end
  end

  mmd_track_if trk ();
  logic oneshot_done, dg_pulse;

  mmd_minmax u_minmax (
    .clock(clock),
    .rst_n(rst_n_ff),
    .t(trk)
  );

  logic [7:0] ctl1_ff, nxt_ctl1, ctl2_ff, nxt_ctl2;
  logic active_ff, nxt_active;
  logic ths_stop_ff, nxt_ths_stop;
  logic clear_ff, nxt_clear;
  logic [7:0] addr_ptr_ff, nxt_addr_ptr;

  mmd_degauss u_degauss (
    .clock(clock),
    .rst_n(rst_n_ff),
    .rst_cnt(ctl2_ff[mmd_pkg::C2_RST_CNT_LSB +: 2]),
    .odr_start(odr_start),
    .wake(active_mode && !active_ff),
    .oneshot_req(ctl1_ff[mmd_pkg::C1_ONESHOT_RST_BIT]),
    .pulse(dg_pulse),
    .oneshot_done(oneshot_done)
  );

  // control registers; a host write of 1 wins over a hardware self-clear
  always_comb begin
    nxt_ctl1 = ctl1_ff;
    nxt_ctl2 = ctl2_ff;
    if (oneshot_done) begin
      nxt_ctl1[mmd_pkg::C1_ONESHOT_RST_BIT] = 1'b0;
    end
    if (trk.clear_done) begin
      nxt_ctl2[mmd_pkg::C2_MAXMIN_RST_BIT] = 1'b0;
    end
    if (reg_wr && addr_ptr_ff == mmd_pkg::ADDR_MAG_CONTROL_ONE) begin
      nxt_ctl1 = reg_wdata;
    end
    if (reg_wr && addr_ptr_ff == mmd_pkg::ADDR_MAG_CONTROL_TWO) begin
      nxt_ctl2 = reg_wdata & mmd_pkg::C2_WRITE_MASK;
    end
  end

  // tracking gate and min/max clear request
  always_comb begin
    nxt_active = active_mode;
    nxt_ths_stop = ths_stop_ff;
    if (!ctl2_ff[mmd_pkg::C2_MAXMIN_DIS_THS_BIT]) begin
      nxt_ths_stop = 1'b0;
    end else if (ths_event) begin
      nxt_ths_stop = 1'b1;
    end
    nxt_clear = 1'b0;
    if (ctl2_ff[mmd_pkg::C2_MAXMIN_RST_BIT] && !clear_ff && !trk.clear_done) begin
      nxt_clear = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ctl1_ff <= mmd_pkg::MAG_CONTROL_ONE_RESET;
      ctl2_ff <= mmd_pkg::MAG_CONTROL_TWO_RESET;
      active_ff <= 1'b0;
      ths_stop_ff <= 1'b0;
      clear_ff <= 1'b0;
    end else begin
      ctl1_ff <= nxt_ctl1;
      ctl2_ff <= nxt_ctl2;
      active_ff <= nxt_active;
      ths_stop_ff <= nxt_ths_stop;
      clear_ff <= nxt_clear;
    end
  end

  // tracker connections
  assign trk.track_en = !ctl2_ff[mmd_pkg::C2_MAXMIN_DIS_BIT] && !ths_stop_ff;
  assign trk.clear = clear_ff;
  assign trk.sample_valid = sample_valid;
  assign trk.sample = mag_sample;

  // burst address pointer
  logic hyb_jump;
  always_comb begin
    hyb_jump = 1'b0;
    if (ctl2_ff[mmd_pkg::C2_HYB_AUTOINC_BIT]) begin
      if (fast_read) begin
        hyb_jump = (addr_ptr_ff == mmd_pkg::ADDR_OUT_Z_MSB);
      end else begin
        hyb_jump = (addr_ptr_ff == mmd_pkg::ADDR_OUT_Z_LSB);
      end
    end
    nxt_addr_ptr = addr_ptr_ff;
    if (reg_start) begin
      nxt_addr_ptr = reg_addr;
    end else if (reg_rd && hyb_jump) begin
      nxt_addr_ptr = mmd_pkg::ADDR_MAG_OUT_X_MSB;
    end else if (reg_rd || reg_wr) begin
      nxt_addr_ptr = addr_ptr_ff + 8'h01;
    end
  end

  // read data mux for the registers this block owns
  logic [7:0] rdata_ff, nxt_rdata;
  always_comb begin
    nxt_rdata = rdata_ff;
    if (reg_rd) begin
      case (addr_ptr_ff)
        mmd_pkg::ADDR_MAG_CONTROL_ONE: nxt_rdata = ctl1_ff;
        mmd_pkg::ADDR_MAG_CONTROL_TWO: nxt_rdata = ctl2_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // auto-calibration offsets from the tracked extremes
  logic [3*W-1:0] off_ff, nxt_off;
  always_comb begin
    nxt_off = off_ff;
    if (odr_end && ctl1_ff[mmd_pkg::C1_ACAL_BIT]) begin
      for (int a = 0; a < 3; a++) begin
        nxt_off[a*W +: W] = avg2(trk.max_val[a*W +: W], trk.min_val[a*W +: W]);
      end
    end
  end

  // output registers
  logic hyb_ff, dg_ff;
  logic [3*W-1:0] max_ff, min_ff;
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      addr_ptr_ff <= 8'h00;
      rdata_ff <= 8'h00;
      off_ff <= '0;
      hyb_ff <= 1'b0;
      dg_ff <= 1'b0;
      max_ff <= {3{mmd_pkg::MAX_RESET}};
      min_ff <= {3{mmd_pkg::MIN_RESET}};
    end else begin
      addr_ptr_ff <= nxt_addr_ptr;
      rdata_ff <= nxt_rdata;
      off_ff <= nxt_off;
      hyb_ff <= (ctl1_ff[mmd_pkg::C1_HMS_LSB +: 2] == mmd_pkg::HMS_HYBRID);
      dg_ff <= dg_pulse;
      max_ff <= trk.max_val;
      min_ff <= trk.min_val;
    end
  end

  assign addr_ptr = addr_ptr_ff;
  assign reg_rdata = rdata_ff;
  assign hybrid_mode = hyb_ff;
  assign degauss_pulse = dg_ff;
  assign max_out = max_ff;
  assign min_out = min_ff;
  assign offset_out = off_ff;
endmodule : mmd_ctrl

// ==== mmd_ctrl_asserts.sv ====
// Purpose: port checks for burst pointer, extreme tracking and degauss pulse
// Assumes: register writes land at addr_ptr on the reg_wr edge
// Notes: keeps its own shadow of control two from observed writes
module mmd_ctrl_asserts (
  input wire logic clock,
  input wire logic resetn,
  input wire logic reg_start,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic fast_read,
  input wire logic active_mode,
  input wire logic odr_start,
  input wire logic sample_valid,
  input wire logic [7:0] addr_ptr,
  input wire logic degauss_pulse,
  input wire logic [3*mmd_pkg::SAMPLE_W-1:0] max_out,
  input wire logic [3*mmd_pkg::SAMPLE_W-1:0] min_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] c2_ff, nxt_c2;
  logic [4:0] pc_ff, nxt_pc;
  logic c2_wr;
  assign c2_wr = reg_wr && !reg_start && addr_ptr == mmd_pkg::ADDR_MAG_CONTROL_TWO;
  // shadow of control two and length of the running pulse
  always_comb begin
    nxt_c2 = c2_wr ? (reg_wdata & mmd_pkg::C2_WRITE_MASK) : c2_ff;
    nxt_pc = degauss_pulse ? pc_ff + 5'h01 : 5'h00;
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      c2_ff <= mmd_pkg::MAG_CONTROL_TWO_RESET;
      pc_ff <= 5'h00;
    end else begin
      c2_ff <= nxt_c2;
      pc_ff <= nxt_pc;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  a_ptr_slow_jump:
  assert property (reg_rd && !reg_start && c2_ff[5] && !fast_read && addr_ptr == 8'h06
    |=> addr_ptr == 8'h33) else $error("pointer missed jump after z low byte");
  a_ptr_fast_jump:
  assert property (reg_rd && !reg_start && c2_ff[5] && fast_read && addr_ptr == 8'h05
    |=> addr_ptr == 8'h33) else $error("pointer missed jump after z high byte");
  a_ptr_plain_step:
  assert property (reg_rd && !reg_start && !c2_ff[5]
    |=> addr_ptr == $past(addr_ptr) + 8'h01) else $error("pointer did not step by one");
  a_extreme_clear:
  assert property (c2_wr && reg_wdata[2] |-> ##[1:4] (min_out == {3{16'h7fff}}
    && max_out == {3{16'h8000}})) else $error("extremes not loaded with full scale");
  a_hold_disabled:
  assert property (sample_valid && c2_ff[4] |-> ##2 ($stable(max_out) && $stable(min_out)))
    else $error("extremes moved while tracking off");
  a_pulse_length:
  assert property ($fell(degauss_pulse) |-> pc_ff == 5'h14) else $error("pulse length wrong");
  a_wake_degauss:
  assert property ($rose(active_mode) |-> ##[1:4] degauss_pulse) else $error("no wake degauss");
  a_every_cycle:
  assert property (odr_start && c2_ff[1:0] == 2'h0 |-> ##[1:4] degauss_pulse)
    else $error("no degauss at cycle start");
endmodule : mmd_ctrl_asserts

bind mmd_ctrl mmd_ctrl_asserts u_chk (.clock(clock), .resetn(resetn), .reg_start(reg_start),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .fast_read(fast_read),
  .active_mode(active_mode), .odr_start(odr_start), .sample_valid(sample_valid),
  .addr_ptr(addr_ptr), .degauss_pulse(degauss_pulse), .max_out(max_out), .min_out(min_out));

// ==== mmd_host.sv ====
// Purpose: host side of the register port
// Assumes: tasks are entered just after a rising edge
// Notes: released address and data show the inverse of the last value
module mmd_host (
  input wire logic clock,
  input wire logic [7:0] reg_rdata,
  output logic reg_start,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle levels at time zero
  initial begin
    reg_start = 1'b0;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // open a transaction at address a
  task automatic go(input logic [7:0] a);
    reg_start = 1'b1;
    reg_addr = a;
    @(posedge clock) #1;
    reg_start = 1'b0;
    reg_addr = ~a;
  endtask : go
  // one write or read, then an idle cycle
  task automatic op(input logic w, input logic [7:0] d, output logic [7:0] q);
    reg_wr = w;
    reg_rd = !w;
    reg_wdata = d;
    @(posedge clock) #1;
    q = reg_rdata;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = ~d;
    @(posedge clock) #1;
  endtask : op
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
    output logic [7:0] q);
    go(a);
    op(w, d, q);
  endtask : xfer
endmodule : mmd_host

// ==== mmd_ctrl_tb_top.sv ====
// Purpose: self-checking bench for the magnetometer control block
// Assumes: host model drives the register port
// Notes: data-rate cycles are 30 clocks so pulses never merge
module mmd_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, resetn, fast_read, active_mode, odr_start, odr_end, sample_valid, ths_event;
  logic reg_start, reg_wr, reg_rd, hybrid_mode, degauss_pulse, pulse_q;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, addr_ptr;
  logic [47:0] mag_sample, max_out, min_out, offset_out;
  int err_count = 0;
  int tests_run = 0;
  int rises = 0;
  mmd_host u_host (.clock(clock), .reg_rdata(reg_rdata), .reg_start(reg_start),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  mmd_ctrl DUT (.clock(clock), .resetn(resetn), .reg_start(reg_start), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .fast_read(fast_read),
    .active_mode(active_mode), .odr_start(odr_start), .odr_end(odr_end),
    .sample_valid(sample_valid), .mag_sample(mag_sample), .ths_event(ths_event),
    .reg_rdata(reg_rdata), .addr_ptr(addr_ptr), .hybrid_mode(hybrid_mode),
    .degauss_pulse(degauss_pulse), .max_out(max_out), .min_out(min_out),
    .offset_out(offset_out));
  // count rising edges of the degauss pulse
  always @(posedge clock) begin
    pulse_q <= degauss_pulse;
    if (degauss_pulse === 1'b1 && pulse_q === 1'b0) rises <= rises + 1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic smp(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
    mag_sample = {z, y, x};
    sample_valid = 1'b1;
    tick(1);
    sample_valid = 1'b0;
    mag_sample = ~mag_sample;
    tick(3);
  endtask : smp
  task automatic ths();
    ths_event = 1'b1;
    tick(1);
    ths_event = 1'b0;
    tick(2);
  endtask : ths
  task automatic t_ptr();
    logic [7:0] q;
    u_host.xfer(mmd_pkg::ADDR_MAG_CONTROL_TWO, 1'b1, 8'h20, q);
    u_host.go(8'h05);
    u_host.op(1'b0, 8'h00, q);
    u_host.op(1'b0, 8'h00, q);
    chk("slow jump", addr_ptr, 8'h33);
    fast_read = 1'b1;
    u_host.go(8'h05);
    u_host.op(1'b0, 8'h00, q);
    chk("fast jump", addr_ptr, 8'h33);
    u_host.xfer(mmd_pkg::ADDR_MAG_CONTROL_TWO, 1'b1, 8'h00, q);
    u_host.go(8'h05);
    u_host.op(1'b0, 8'h00, q);
    u_host.op(1'b0, 8'h00, q);
    chk("plain step", addr_ptr, 8'h07);
    u_host.xfer(8'h40, 1'b0, 8'h00, q);
    chk("unowned read", q, 8'h00);
    fast_read = 1'b0;
    u_host.xfer(mmd_pkg::ADDR_MAG_CONTROL_ONE, 1'b1, 8'h03, q);
    chk("hybrid on", hybrid_mode, 1'b1);
    u_host.xfer(mmd_pkg::ADDR_MAG_CONTROL_ONE, 1'b1, 8'h01, q);
    chk("hybrid off", hybrid_mode, 1'b0);
  endtask : t_ptr
  task automatic t_mm();
    logic [7:0] q;
    u_host.xfer(mmd_pkg::ADDR_MAG_CONTROL_TWO, 1'b1, 8'h04, q);
    tick(3);
    u_host.xfer(mmd_pkg::ADDR_MAG_CONTROL_TWO, 1'b0, 8'h00, q);
    chk("clear bit", q, 8'h00);
    chk("min clear", min_out, {3{16'h7fff}});
    chk("max clear", max_out, {3{16'h8000}});
    smp(16'h0064, 16'hfffb, 16'h0007);
    smp(16'hff38, 16'h0032, 16'h0007);
    chk("max", max_out, {16'h0007, 16'h0032, 16'h0064});
    chk("min", min_out, {16'h0007, 16'hfffb, 16'hff38});
    u_host.xfer(mmd_pkg::ADDR_MAG_CONTROL_ONE, 1'b1, 8'h80, q);
    odr_end = 1'b1;
    tick(1);
    odr_end = 1'b0;
    tick(3);
    chk("offset", offset_out, {16'h0007, 16'h0016, 16'hffce});
    u_host.xfer(mmd_pkg::ADDR_MAG_CONTROL_TWO, 1'b1, 8'h10, q);
    smp(16'h03e8, 16'h03e8, 16'h03e8);
    chk("max held", max_out, {16'h0007, 16'h0032, 16'h0064});
    u_host.xfer(mmd_pkg::ADDR_MAG_CONTROL_TWO, 1'b1, 8'h00, q);
    ths();
    smp(16'h07d0, 16'h0000, 16'h0000);
    chk("max ths off", max_out, {16'h0007, 16'h0032, 16'h07d0});
    u_host.xfer(mmd_pkg::ADDR_MAG_CONTROL_TWO, 1'b1, 8'h08, q);
    ths();
    smp(16'h0bb8, 16'h0000, 16'h0000);
    chk("max ths stop", max_out, {16'h0007, 16'h0032, 16'h07d0});
    u_host.xfer(mmd_pkg::ADDR_MAG_CONTROL_TWO, 1'b1, 8'h04, q);
    tick(3);
    chk("min reclear", min_out, {3{16'h7fff}});
    chk("max reclear", max_out, {3{16'h8000}});
  endtask : t_mm
  task automatic t_dg();
    logic [7:0] q;
    int base;
    int n[4] = '{4, 32, 512, 4};
    int e[4] = '{4, 2, 1, 0};
    u_host.xfer(mmd_pkg::ADDR_MAG_CONTROL_TWO, 1'b1, 8'h03, q);
    base = rises;
    u_host.xfer(mmd_pkg::ADDR_MAG_CONTROL_ONE, 1'b1, 8'h40, q);
    tick(30);
    u_host.xfer(mmd_pkg::ADDR_MAG_CONTROL_ONE, 1'b0, 8'h00, q);
    chk("one-shot pulses", 48'(rises - base), 48'h1);
    chk("one-shot bit", q, 8'h00);
    base = rises;
    active_mode = 1'b1;
    tick(30);
    chk("wake pulses", 48'(rises - base), 48'h1);
    for (int c = 0; c < 4; c++) begin
      u_host.xfer(mmd_pkg::ADDR_MAG_CONTROL_TWO, 1'b1, 8'(c), q);
      base = rises;
      repeat (n[c]) begin
        odr_start = 1'b1;
        tick(1);
        odr_start = 1'b0;
        tick(29);
      end
      chk("periodic pulses", 48'(rises - base), 48'(e[c]));
    end
  endtask : t_dg
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  // free-running clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // reset, then the scenarios
  initial begin
    resetn = 1'b0;
    {fast_read, active_mode, odr_start, odr_end, sample_valid, ths_event} = 6'h00;
    mag_sample = 48'h0;
    repeat (4) @(posedge clock);
    #1 resetn = 1'b1;
    tick(4);
    t_ptr();
    t_mm();
    t_dg();
    close_out();
  end
  // watchdog well beyond the expected run
  initial begin
    #200000;
    err_count++;
    close_out();
  end
endmodule : mmd_ctrl_tb_top
